// ---- core/xtc_consts.svh ----
`ifndef XTC_CONSTS_SVH
`define XTC_CONSTS_SVH
// Register byte offsets.
`define XTC_OFS_TRIM     8'h00
`define XTC_OFS_TRIMCTRL 8'h04
`define XTC_OFS_OSCCTRL  8'h08
`define XTC_OFS_STATUS   8'h0c
`define XTC_OFS_CALN     8'h10
`define XTC_OFS_CALSEL   8'h14
`define XTC_OFS_CALMLO   8'h18
`define XTC_OFS_CALMHI   8'h1c
`define XTC_OFS_INTSTAT  8'h20
`define XTC_OFS_INTMASK  8'h24
// Field positions.
`define XTC_TRIM_DELAY_LSB 0
`define XTC_SETTLE_LSB     4
`define XTC_OSC_EN_BIT     0
`define XTC_SLEEP_RCX_BIT  1
`define XTC_RCTRIM_LSB     4
`define XTC_CAL_START_BIT  3
`define XTC_EV_READY       0
`define XTC_EV_SETTLED     1
`define XTC_EV_CALDONE     2
// Reset values.
`define XTC_RST_TRIM   11'h000
`define XTC_RST_RCTRIM 5'h00
// Trim code limits.
`define XTC_TRIM_STEPS 2048
// Timing: unit of the trim and settle counters, sleep slot length and sleep-clock periods.
`define XTC_UNIT_US  250
`define XTC_CLK_MHZ  100
`define XTC_SLOT_NS  625000
`define XTC_XT32_NS  30518
`define XTC_RCX_NS   92593
`endif

// ---- core/xtc_pkg.sv ----
package xtc_pkg;
  // System clock source steered by this block.
  typedef enum logic [1:0] {
    SRC_SLOW_RC,
    SRC_FAST_RC,
    SRC_MAIN_XTAL
  } xtc_clksrc_t;
  // Crystal trim sequencer states.
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_TRIM_WAIT,
    SEQ_SETTLE_WAIT,
    SEQ_DONE
  } xtc_seq_t;
endpackage

// ---- core/xtc_trim_osc.sv ----
// Register access over Wishbone and the register addresses are this design's own decisions.
`include "xtc_consts.svh"
module xtc_trim_osc #(
  parameter int TICK_CYCLES = `XTC_UNIT_US * `XTC_CLK_MHZ,
  parameter int N_WIDTH     = 16,
  parameter int RCX_NS      = `XTC_RCX_NS
) (
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic                mirrorActive,
  input  wire logic [3:0]          measClkPin,
  output logic                     xtalEnable,
  output logic      [7:0]          fineCapSw,
  output logic      [6:0]          coarseCapSw,
  output logic      [4:0]          fastRcTrim,
  output xtc_pkg::xtc_clksrc_t     sysClkSrc,
  output logic                     sleepUseRcx,
  output logic                     sleepSlotTick,
  output logic                     irq
);
  ////////////////////////////////////////////////////////////////////////////
  // Thermometer decode of the coarse field: codes 0 and 1 both give one line, then one more line per step.
  function automatic logic [6:0] thermo(input logic [2:0] c);
    logic [6:0] t;
    t = 7'h00;
    for (int i = 0; i < 7; i++) begin
      t[i] = (i == 0) || (c > 3'(i));
    end
    return t;
  endfunction
  logic [10:0]          trimCode_q;
  logic [3:0]           trimDelay_q;
  logic [3:0]           settleCnt_q;
  logic                 oscEn_q;
  logic                 sleepRcx_q;
  logic [4:0]           rcTrim_q;
  logic [N_WIDTH-1:0]   calN_q;
  logic [2:0]           calSel_q;
  logic                 calRun_q;
  logic [31:0]          calM_q;
  logic [2:0]           intStat_q;
  logic [2:0]           intMask_q;
  logic                 ack_q;
  logic [31:0]          rdat_q;
  logic                 wrEn;
  logic                 rdEn;
  logic                 calStartWr;
  logic [2:0]           evPulse;
  logic                 trimReady_q;
  logic                 settled_q;
  ////////////////////////////////////////////////////////////////////////////
  // Classic Wishbone slave: one access per ack, ack one cycle after request.
  assign wrEn = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
  assign rdEn = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q;
  assign calStartWr = wrEn && wb_sel_i[0] && (wb_adr_i == `XTC_OFS_CALSEL)
                      && wb_dat_i[`XTC_CAL_START_BIT] && wb_dat_i[2];
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
    end
  end
  // Control registers; byte lanes honoured except that lane 0 of OSCCTRL also loads rcTrim bit 4 from lane 1, start bit handled with the counter.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      trimCode_q  <= `XTC_RST_TRIM;
      trimDelay_q <= 4'h0;
      settleCnt_q <= 4'h0;
      oscEn_q     <= 1'b0;
      sleepRcx_q  <= 1'b0;
      rcTrim_q    <= `XTC_RST_RCTRIM;
      calN_q      <= '0;
      calSel_q    <= 3'h0;
      intMask_q   <= 3'h0;
    end else if (wrEn) begin
      if (wb_adr_i == `XTC_OFS_TRIM) begin
        if (wb_sel_i[0]) trimCode_q[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) trimCode_q[10:8] <= wb_dat_i[10:8];
      end else if (wb_adr_i == `XTC_OFS_TRIMCTRL) begin
        if (wb_sel_i[0]) begin
          trimDelay_q <= wb_dat_i[`XTC_TRIM_DELAY_LSB +: 4];
          settleCnt_q <= wb_dat_i[`XTC_SETTLE_LSB +: 4];
        end
      end else if (wb_adr_i == `XTC_OFS_OSCCTRL) begin
        if (wb_sel_i[0]) begin
          oscEn_q    <= wb_dat_i[`XTC_OSC_EN_BIT];
          sleepRcx_q <= wb_dat_i[`XTC_SLEEP_RCX_BIT];
          rcTrim_q   <= {wb_dat_i[8], wb_dat_i[`XTC_RCTRIM_LSB +: 4]};
        end else if (wb_sel_i[1]) begin
          rcTrim_q[4] <= wb_dat_i[8];
        end
      end else if (wb_adr_i == `XTC_OFS_CALN) begin
        for (int i = 0; i < N_WIDTH; i++) begin
          if (wb_sel_i[i / 8]) calN_q[i] <= wb_dat_i[i];
        end
      end else if (wb_adr_i == `XTC_OFS_CALSEL) begin
        if (wb_sel_i[0] && !calRun_q) calSel_q <= wb_dat_i[2:0];
      end else if (wb_adr_i == `XTC_OFS_INTMASK) begin
        if (wb_sel_i[0]) intMask_q <= wb_dat_i[2:0];
      end
    end
  end
  // Read data is registered and presented together with ack.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdat_q <= 32'h0000_0000;
    end else if (rdEn) begin
      rdat_q <= 32'h0000_0000;
      if (wb_adr_i == `XTC_OFS_TRIM) begin
        rdat_q[10:0] <= trimCode_q;
      end else if (wb_adr_i == `XTC_OFS_TRIMCTRL) begin
        rdat_q[7:0] <= {settleCnt_q, trimDelay_q};
      end else if (wb_adr_i == `XTC_OFS_OSCCTRL) begin
        rdat_q[8:0] <= {rcTrim_q, 2'b00, sleepRcx_q, oscEn_q};
      end else if (wb_adr_i == `XTC_OFS_STATUS) begin
        rdat_q[1:0] <= {settled_q, trimReady_q};
      end else if (wb_adr_i == `XTC_OFS_CALN) begin
        rdat_q[N_WIDTH-1:0] <= calN_q;
      end else if (wb_adr_i == `XTC_OFS_CALSEL) begin
        rdat_q[3:0] <= {calRun_q, calSel_q};
      end else if (wb_adr_i == `XTC_OFS_CALMLO) begin
        rdat_q[15:0] <= calM_q[15:0];
      end else if (wb_adr_i == `XTC_OFS_CALMHI) begin
        rdat_q[15:0] <= calM_q[31:16];
      end else if (wb_adr_i == `XTC_OFS_INTSTAT) begin
        rdat_q[2:0] <= intStat_q;
      end else if (wb_adr_i == `XTC_OFS_INTMASK) begin
        rdat_q[2:0] <= intMask_q;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Trim sequencer. The tick divider restarts on every enable so the first
  // unit is always a full 250 us.
  xtc_pkg::xtc_seq_t  seq_q;
  logic [3:0]         unitCnt_q;
  logic [31:0]        tickCnt_q;
  logic               tick;
  logic               oscEnDly_q;
  logic               enRise;
  assign enRise = oscEn_q && !oscEnDly_q;
  assign tick   = (tickCnt_q == 32'(TICK_CYCLES - 1));
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      oscEnDly_q <= 1'b0;
      tickCnt_q  <= 32'h0000_0000;
    end else begin
      oscEnDly_q <= oscEn_q;
      if (enRise || tick || seq_q == xtc_pkg::SEQ_IDLE) begin
        tickCnt_q <= 32'h0000_0000;
      end else begin
        tickCnt_q <= tickCnt_q + 32'h0000_0001;
      end
    end
  end
  // Sequencer states; the flags follow the state so they clear with it.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      seq_q     <= xtc_pkg::SEQ_IDLE;
      unitCnt_q <= 4'h0;
    end else if (!oscEn_q) begin
      seq_q     <= xtc_pkg::SEQ_IDLE;
      unitCnt_q <= 4'h0;
    end else begin
      case (seq_q)
        xtc_pkg::SEQ_IDLE: begin
          unitCnt_q <= 4'h0;
          if (trimDelay_q == 4'h0) begin
            seq_q <= (settleCnt_q == 4'h0) ? xtc_pkg::SEQ_DONE : xtc_pkg::SEQ_SETTLE_WAIT;
          end else begin
            seq_q <= xtc_pkg::SEQ_TRIM_WAIT;
          end
        end
        xtc_pkg::SEQ_TRIM_WAIT: begin
          if (tick) begin
            if (unitCnt_q + 4'h1 == trimDelay_q) begin
              unitCnt_q <= 4'h0;
              seq_q <= (settleCnt_q == 4'h0) ? xtc_pkg::SEQ_DONE : xtc_pkg::SEQ_SETTLE_WAIT;
            end else begin
              unitCnt_q <= unitCnt_q + 4'h1;
            end
          end
        end
        xtc_pkg::SEQ_SETTLE_WAIT: begin
          if (tick) begin
            if (unitCnt_q + 4'h1 == settleCnt_q) begin
              seq_q <= xtc_pkg::SEQ_DONE;
            end else begin
              unitCnt_q <= unitCnt_q + 4'h1;
            end
          end
        end
        default: begin
          seq_q <= xtc_pkg::SEQ_DONE;
        end
      endcase
    end
  end
  assign trimReady_q = (seq_q == xtc_pkg::SEQ_SETTLE_WAIT) || (seq_q == xtc_pkg::SEQ_DONE);
  assign settled_q   = (seq_q == xtc_pkg::SEQ_DONE);
  // Capacitor switches: the stored code reaches the oscillator only once
  // the trim delay has run out; before that the bank keeps its last applied code, the reset code until the first.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fineCapSw   <= 8'h00;
      coarseCapSw <= 7'h01;
    end else if (trimReady_q) begin
      fineCapSw   <= trimCode_q[7:0];
      coarseCapSw <= thermo(trimCode_q[10:8]);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Measured clock pins are asynchronous: two stages, then an edge stage.
  logic [3:0] pinS1_q;
  logic [3:0] pinS2_q;
  logic [3:0] pinS3_q;
  logic [3:0] pinRise;
  generate
    for (genvar g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          pinS1_q[g] <= 1'b0;
          pinS2_q[g] <= 1'b0;
          pinS3_q[g] <= 1'b0;
        end else begin
          pinS1_q[g] <= measClkPin[g];
          pinS2_q[g] <= pinS1_q[g];
          pinS3_q[g] <= pinS2_q[g];
        end
      end
      assign pinRise[g] = pinS2_q[g] && !pinS3_q[g];
    end
  endgenerate
  // Reference counter: counts N edges of the chosen clock and M system
  // cycles. Start is taken only with a select of 4 to 7.
  logic [N_WIDTH-1:0] edgeCnt_q;
  logic [31:0]        mCnt_q;
  logic               calEnd;
  assign calEnd = calRun_q && pinRise[calSel_q[1:0]] && (edgeCnt_q + 1'b1 >= calN_q);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      calRun_q  <= 1'b0;
      edgeCnt_q <= '0;
      mCnt_q    <= 32'h0000_0000;
      calM_q    <= 32'h0000_0000;
    end else if (calStartWr && !calRun_q) begin
      calRun_q  <= 1'b1;
      edgeCnt_q <= '0;
      mCnt_q    <= 32'h0000_0000;
    end else if (calRun_q) begin
      mCnt_q <= mCnt_q + 32'h0000_0001;
      if (calEnd) begin
        calRun_q <= 1'b0;
        calM_q   <= mCnt_q + 32'h0000_0001;
      end else if (pinRise[calSel_q[1:0]]) begin
        edgeCnt_q <= edgeCnt_q + 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // System and sleep clock selection.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sysClkSrc <= xtc_pkg::SRC_SLOW_RC;
    end else if (settled_q) begin
      sysClkSrc <= xtc_pkg::SRC_MAIN_XTAL;
    end else if (mirrorActive) begin
      sysClkSrc <= xtc_pkg::SRC_FAST_RC;
    end else begin
      sysClkSrc <= xtc_pkg::SRC_SLOW_RC;
    end
  end
  // Slot counter adds each sleep-clock period in ns, so a 10.8 kHz enhanced RC
  // yields the same 625 us slots as the untrimmed slow crystal.
  logic [19:0] slotAcc_q;
  logic [19:0] slotNext;
  logic        sleepEdge;
  assign sleepEdge = sleepRcx_q ? pinRise[3] : pinRise[2];
  assign slotNext  = slotAcc_q + (sleepRcx_q ? 20'(RCX_NS) : 20'(`XTC_XT32_NS));
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      slotAcc_q     <= 20'h00000;
      sleepSlotTick <= 1'b0;
    end else begin
      sleepSlotTick <= 1'b0;
      if (sleepEdge) begin
        if (slotNext >= 20'(`XTC_SLOT_NS)) begin
          slotAcc_q     <= slotNext - 20'(`XTC_SLOT_NS);
          sleepSlotTick <= 1'b1;
        end else begin
          slotAcc_q <= slotNext;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Sticky event bits, write one to clear; a new event wins over the clear.
  logic readyDly_q;
  logic settledDly_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      readyDly_q   <= 1'b0;
      settledDly_q <= 1'b0;
    end else begin
      readyDly_q   <= trimReady_q;
      settledDly_q <= settled_q;
    end
  end
  assign evPulse = {calEnd, settled_q && !settledDly_q, trimReady_q && !readyDly_q};
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      intStat_q <= 3'h0;
    end else begin
      if (wrEn && wb_sel_i[0] && wb_adr_i == `XTC_OFS_INTSTAT) begin
        intStat_q <= (intStat_q & ~wb_dat_i[2:0]) | evPulse;
      end else begin
        intStat_q <= intStat_q | evPulse;
      end
    end
  end
  // Outputs straight from flip-flops.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq         <= 1'b0;
      xtalEnable  <= 1'b0;
      fastRcTrim  <= `XTC_RST_RCTRIM;
      sleepUseRcx <= 1'b0;
    end else begin
      irq         <= |(intStat_q & intMask_q);
      xtalEnable  <= oscEn_q;
      fastRcTrim  <= rcTrim_q;
      sleepUseRcx <= sleepRcx_q;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence enableStart;
    $rose(oscEn_q);
  endsequence
  zero_delay_a: assert property (enableStart ##0 (trimDelay_q == 4'h0) |=> trimReady_q)
    else $error("trim not applied at once with zero delay");
  trim_wait_a: assert property (enableStart ##0 (trimDelay_q != 4'h0) |=> !trimReady_q [*3])
    else $error("trim ready came before the delay");
  flag_clear_a: assert property (!oscEn_q |=> !trimReady_q && !settled_q)
    else $error("flags not cleared on disable");
  settle_order_a: assert property (settled_q |-> trimReady_q)
    else $error("settled without trim ready");
  fine_apply_a: assert property (trimReady_q |=> fineCapSw == 8'($past(trimCode_q)))
    else $error("fine switches differ from code");
  coarse_line_a: assert property (trimReady_q ##1 $stable(trimCode_q)
      |-> $countones(coarseCapSw) == ((trimCode_q[10:8] == 3'h0) ? 1 : int'(trimCode_q[10:8])))
    else $error("coarse thermometer wrong");
  cal_clear_a: assert property (calEnd |=> !calRun_q && intStat_q[`XTC_EV_CALDONE])
    else $error("calibration end not flagged");
  bus_ack_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  irq_level_a: assert property (irq == |($past(intStat_q) & $past(intMask_q)))
    else $error("interrupt does not follow status");
  mirror_clk_a: assert property (mirrorActive && !settled_q |=> sysClkSrc == xtc_pkg::SRC_FAST_RC)
    else $error("fast rc not used during mirroring");
endmodule

// ---- tb/tb.sv ----
`include "xtc_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF_NS [4] = '{200, 30, 150, 250};
  logic                 clk_sys;
  logic                 rstn;
  logic                 wbCyc;
  logic                 wbStb;
  logic                 wbWe;
  logic [7:0]           wbAdr;
  logic [3:0]           wbSel;
  logic [31:0]          wbDatW;
  logic [31:0]          wbDatR;
  logic                 wb_ack_o;
  logic                 mirrorActive;
  logic [3:0]           measClkPin;
  logic                 xtalEnable;
  logic [7:0]           fineCapSw;
  logic [6:0]           coarseCapSw;
  logic [4:0]           fastRcTrim;
  xtc_pkg::xtc_clksrc_t sysClkSrc;
  logic                 sleepUseRcx;
  logic                 sleepSlotTick;
  logic                 irq;
  logic [11:0]          capUnits;
  logic [31:0]          rdv;
  logic [31:0]          monE;
  logic [31:0]          monM;
  logic [31:0]          expQ [$];
  logic [31:0]          mskQ [$];
  int                   fails;
  int                   totalChecks;

  xtc_trim_osc #(.TICK_CYCLES(4)) uut (
    .clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wb_ack_o),
    .mirrorActive(mirrorActive), .measClkPin(measClkPin), .xtalEnable(xtalEnable),
    .fineCapSw(fineCapSw), .coarseCapSw(coarseCapSw), .fastRcTrim(fastRcTrim), .sysClkSrc(sysClkSrc),
    .sleepUseRcx(sleepUseRcx), .sleepSlotTick(sleepSlotTick), .irq(irq)
  );

  xtc_osc_model #(.HALF0_NS(HALF_NS[0]), .HALF1_NS(HALF_NS[1]), .HALF2_NS(HALF_NS[2]),
                  .HALF3_NS(HALF_NS[3])) osc (
    .measClkPin(measClkPin), .fineCapSw(fineCapSw), .coarseCapSw(coarseCapSw), .capUnits(capUnits)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Free-running 100 MHz system clock.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // One classic Wishbone cycle; the request stands until ack is sampled high.
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                      output logic [31:0] rd);
    int n;
    @(posedge clk_sys);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatW <= we ? d : 32'h0;
    if (!we) begin
      expQ.push_back(d);
      mskQ.push_back(m);
    end
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      fails++;
      $display("mismatch bus ack expected 1 seen %b", wb_ack_o);
      results();
    end
    rd = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0, rdv);
  endtask

  task automatic rdx(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    xfer(1'b0, a, e, m, rdv);
  endtask

  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  // Counts cycles until the fine bank shows a code, or until irq rises.
  task automatic waitSig(input logic [7:0] f, input logic useIrq, output int n);
    n = 0;
    while ((useIrq ? irq !== 1'b1 : fineCapSw !== f) && n < 100) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 100) begin
      fails++;
      $display("mismatch wait expected %h seen %h", useIrq ? 8'h01 : f, useIrq ? 8'(irq) : fineCapSw);
      results();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Read answers are judged here against the oldest note; a zero mask skips the value.
  always @(posedge clk_sys) begin
    if (wb_ack_o === 1'b1 && wbWe === 1'b0 && wbCyc === 1'b1 && expQ.size() > 0) begin
      monE = expQ.pop_front();
      monM = mskQ.pop_front();
      chk("read data", monE & monM, wbDatR & monM);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    int n;
    int k;
    int e;
    int p;
    logic [7:0] fine;
    logic [31:0] lo;
    logic [31:0] mVal;
    logic [31:0] nVal;
    logic pv;
    {wbCyc, wbStb, wbWe, mirrorActive} = 4'h0;
    {wbAdr, wbSel, wbDatW} = {8'h00, 4'hf, 32'h0};
    {fails, totalChecks} = {32'sd0, 32'sd0};
    rstn = 1'b0;
    void'($urandom(32'haefc));
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    #1;
    chk("coarse at reset", 32'h01, 32'(coarseCapSw));
    chk("fast rc trim at reset", 32'h0, 32'(fastRcTrim));
    chk("clock source at reset", 32'(xtc_pkg::SRC_SLOW_RC), 32'(sysClkSrc));
    rdx(`XTC_OFS_TRIM, 32'h0, 32'h7ff);
    rdx(`XTC_OFS_OSCCTRL, 32'h0, 32'h1f0);
    rdx(`XTC_OFS_STATUS, 32'h0, 32'h3);
    rdx(8'h30, 32'h0, 32'hffffffff);
    $display("test reset values done");
    // Zero trim delay, then walk the coarse field one step per write.
    wr(`XTC_OFS_TRIM, 32'h155);
    wr(`XTC_OFS_TRIMCTRL, 32'h10);
    wr(`XTC_OFS_OSCCTRL, 32'h1);
    waitSig(8'h55, 1'b0, n);
    chk("zero delay wait", 32'h1, 32'(n <= 2));
    chk("crystal enable", 32'h1, 32'(xtalEnable));
    for (int c = 0; c < 8; c++) begin
      fine = (c == 7) ? 8'hff : 8'($urandom);
      wr(`XTC_OFS_TRIM, {21'h0, 3'(c), fine});
      settle();
      e = (c == 0) ? 1 : c;
      chk("fine switches", 32'(fine), 32'(fineCapSw));
      chk("coarse switches", 32'((1 << e) - 1), 32'(coarseCapSw));
      chk("switched capacitance", 32'(fine) + 32'(256 * e), 32'(capUnits));
      rdx(`XTC_OFS_TRIM, {21'h0, 3'(c), fine}, 32'h7ff);
    end
    $display("test trim decode done");
    // Status events stay sticky; the mask gates the interrupt line.
    rdx(`XTC_OFS_INTSTAT, 32'h3, 32'h3);
    settle();
    chk("irq masked", 32'h0, 32'(irq));
    wr(`XTC_OFS_INTMASK, 32'h1);
    settle();
    chk("irq unmasked", 32'h1, 32'(irq));
    wr(`XTC_OFS_INTSTAT, 32'h1);
    settle();
    chk("irq after clear", 32'h0, 32'(irq));
    rdx(`XTC_OFS_INTSTAT, 32'h2, 32'h3);
    wr(`XTC_OFS_INTSTAT, 32'h7);
    $display("test interrupt done");
    // Counted trim delay and settle time, with mirroring running meanwhile.
    wr(`XTC_OFS_OSCCTRL, 32'h0);
    rdx(`XTC_OFS_STATUS, 32'h0, 32'h3);
    chk("crystal disable", 32'h0, 32'(xtalEnable));
    wr(`XTC_OFS_TRIMCTRL, 32'h33);
    wr(`XTC_OFS_TRIM, 32'h73c);
    wr(`XTC_OFS_INTMASK, 32'h2);
    mirrorActive <= 1'b1;
    wr(`XTC_OFS_OSCCTRL, 32'h1);
    settle();
    chk("clock source mirroring", 32'(xtc_pkg::SRC_FAST_RC), 32'(sysClkSrc));
    waitSig(8'h3c, 1'b0, n);
    chk("trim delay cycles", 32'h1, 32'(n >= 7 && n <= 12));
    waitSig(8'h0, 1'b1, n);
    chk("settle cycles", 32'h1, 32'(n >= 11 && n <= 18));
    chk("clock source settled", 32'(xtc_pkg::SRC_MAIN_XTAL), 32'(sysClkSrc));
    rdx(`XTC_OFS_STATUS, 32'h3, 32'h3);
    mirrorActive <= 1'b0;
    $display("test trim sequencer done");
    // Reference counter over select codes 4 to 7, plus a refused select of 3.
    wr(`XTC_OFS_INTSTAT, 32'h7);
    wr(`XTC_OFS_INTMASK, 32'h4);
    for (int s = 4; s < 8; s++) begin
      nVal = 32'd2 + ($urandom % 3);
      p = HALF_NS[s - 4] / 5;
      wr(`XTC_OFS_CALN, nVal);
      wr(`XTC_OFS_CALSEL, 32'(8 + s));
      k = 0;
      do begin
        rdx(`XTC_OFS_CALSEL, 32'h0, 32'h0);
        k++;
      end while (rdv[3] !== 1'b0 && k < 200);
      chk("calibration start bit", 32'h0, 32'(rdv[3]));
      rdx(`XTC_OFS_CALMLO, 32'h0, 32'h0);
      lo = rdv;
      rdx(`XTC_OFS_CALMHI, 32'h0, 32'h0);
      mVal = {rdv[15:0], lo[15:0]};
      chk("calibration result", 32'h1, 32'(mVal >= (nVal - 1) * p && mVal <= nVal * p + 6));
      settle();
      chk("irq on calibration", 32'h1, 32'(irq));
      wr(`XTC_OFS_INTSTAT, 32'h4);
    end
    wr(`XTC_OFS_CALSEL, 32'h0b);
    rdx(`XTC_OFS_CALSEL, 32'h0, 32'h8);
    $display("test calibration done");
    // Sleep slots counted in sleep-clock edges, crystal first, then enhanced RC.
    for (int r = 0; r < 2; r++) begin
      p = $urandom % 32;
      wr(`XTC_OFS_OSCCTRL, 32'(1 + 2 * r + 16 * p));
      settle();
      chk("sleep clock choice", 32'(r), 32'(sleepUseRcx));
      chk("fast rc trim", 32'(p), 32'(fastRcTrim));
      k = 0;
      while (sleepSlotTick !== 1'b1 && k < 3000) begin
        @(posedge clk_sys);
        #1;
        k++;
      end
      e = 0;
      pv = measClkPin[2 + r];
      do begin
        @(posedge clk_sys);
        #1;
        k++;
        if (measClkPin[2 + r] && !pv) e++;
        pv = measClkPin[2 + r];
      end while (sleepSlotTick !== 1'b1 && k < 3000);
      chk("sleep slot timeout", 32'h1, 32'(k < 3000));
      chk("edges per slot", 32'h1, 32'(r ? (e >= 6 && e <= 8) : (e >= 19 && e <= 22)));
    end
    $display("test sleep slots done");
    results();
  end
endmodule

// ---- tb/xtc_osc_model.sv ----
// Behavioural stand-in for the oscillator cells behind the trim and clock pins.
module xtc_osc_model #(
  parameter int HALF0_NS = 200,
  parameter int HALF1_NS = 30,
  parameter int HALF2_NS = 150,
  parameter int HALF3_NS = 250
) (
  output logic       [3:0]  measClkPin,
  input  wire logic  [7:0]  fineCapSw,
  input  wire logic  [6:0]  coarseCapSw,
  output logic       [11:0] capUnits
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // The oscillators run free; start phases are staggered so no two pins move together.
  // Pin 0 is the slow RC used at startup, pin 2 the untrimmed slow crystal.
  initial begin
    measClkPin = 4'h0;
    fork
      forever #(HALF0_NS) measClkPin[0] = ~measClkPin[0];
      #3 forever #(HALF1_NS) measClkPin[1] = ~measClkPin[1];
      #7 forever #(HALF2_NS) measClkPin[2] = ~measClkPin[2];
      #11 forever #(HALF3_NS) measClkPin[3] = ~measClkPin[3];
    join
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capacitance switched by the banks, in units of the smallest fine capacitor.
  // Each coarse line weighs 256 units, so a coarse step equals a full fine sweep plus one.
  always_comb begin
    capUnits = 12'(fineCapSw) + 12'(256 * $countones(coarseCapSw));
  end
endmodule
